// >>> inc/blanking_pkg.sv
package blanking_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] offset_setting_addr = 8'h00;
    localparam logic [7:0] offset_count_addr = 8'h04;
    localparam logic [7:0] window_width_addr = 8'h08;
    localparam logic [7:0] window_count_addr = 8'h0c;
    localparam logic [7:0] filter_control_addr = 8'h10;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int offset_width = 16;
    localparam int window_bits = 8;
    localparam int reference_select_bit = 0;
    localparam logic [15:0] offset_setting_reset = 16'h0000;
    localparam logic [7:0] window_width_reset = 8'h00;
    localparam logic [15:0] offset_count_reset = 16'h0000;
    localparam logic [7:0] window_count_reset = 8'h00;

    // ****************************************
    // reference point choices
    // ****************************************
    localparam logic reference_is_period = 1'b0;
    localparam logic reference_is_zero = 1'b1;

    // ****************************************
    // bus responses
    // ****************************************
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef enum logic [1:0] {write_idle, write_resp} write_state_type;
endpackage

// >>> src/blanking_window_counters.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RQ1 - offset counter value readable as 16-bit field; writes never change it
// RQ2 - offset counter counts down to zero, holds until next reference reload
// RQ3 - offset counter ignores emulation halt and keeps counting
// RQ4 - width setting of zero produces no blanking window
// RQ5 - nonzero width gives window lasting that many time-base cycles
// RQ6 - offset expiry loads window counter with width and starts it
// RQ7 - offset expiry during active window restarts window counter
// RQ8 - active window continues across a period boundary
// RQ9 - window counter value readable as 8-bit read-only field
// RQ10 - window counter counts to zero, holds, reloads only on offset expiry
// RQ11 - software writes zeros to upper byte of window counter register
// RQ12 - active offset loaded from shadow at reference point, counter starts
// RQ13 - offset counted in time-base cycles from period or zero event
// RQ14 - blanking active from window start until window counter reaches zero
module blanking_window_counters
    import blanking_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic period_event,
    input wire logic zero_event,
    input wire logic emulation_halt,
    output logic blanking_active,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************
    // state
    // ****************************************
    logic [15:0] blanking_offset_setting;
    logic [15:0] active_offset;
    logic [15:0] offset_count_value;
    logic offset_running;
    logic [7:0] blanking_window_width;
    logic [7:0] window_count_value;
    logic reference_point_select;
    logic reference_event;
    logic offset_expire;
    logic [7:0] write_addr;
    logic [31:0] write_data;
    logic [3:0] write_strb;
    logic have_addr;
    logic have_data;
    logic do_write;
    write_state_type write_state;

    // ****************************************
    // lane merge and address decode
    // ****************************************
    function automatic logic [15:0] merge_lanes(input logic [15:0] old_value,
        input logic [31:0] data, input logic [3:0] strb);
        logic [15:0] result;
        result = old_value;
        if (strb[0])
        begin
            result[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        return addr == offset_setting_addr || addr == offset_count_addr
            || addr == window_width_addr || addr == window_count_addr
            || addr == filter_control_addr;
    endfunction

    // ****************************************
    // reference point and expiry
    // ****************************************
    always_comb
    begin
        reference_event = (reference_point_select == reference_is_zero)
            ? zero_event : period_event; // [RQ13]
        offset_expire = offset_running && !reference_event
            && (offset_count_value == 16'h0001); // [RQ6]
    end

    // ****************************************
    // offset counter, free of emulation halt
    // ****************************************
    // emulation_halt left unread on purpose [RQ3]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            active_offset <= offset_setting_reset;
            offset_count_value <= offset_count_reset;
            offset_running <= 1'b0;
        end
        else if (reference_event)
        begin
            active_offset <= blanking_offset_setting; // [RQ12]
            offset_count_value <= blanking_offset_setting; // [RQ12]
            offset_running <= blanking_offset_setting != 16'h0000;
        end
        else if (offset_count_value != 16'h0000)
        begin
            offset_count_value <= offset_count_value - 16'h0001; // [RQ2] [RQ3] [RQ14]
            offset_running <= offset_count_value != 16'h0001;
        end
        else
        begin
            offset_running <= 1'b0; // [RQ2]
        end
    end

    // ****************************************
    // window counter and blanking output
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            window_count_value <= window_count_reset;
            blanking_active <= 1'b0;
        end
        else if (offset_expire)
        begin
            window_count_value <= blanking_window_width; // [RQ6] [RQ7] [RQ10]
            blanking_active <= blanking_window_width != 8'h00; // [RQ4] [RQ5]
        end
        else if (window_count_value != 8'h00)
        begin
            window_count_value <= window_count_value - 8'h01; // [RQ5] [RQ8] [RQ10]
            blanking_active <= window_count_value != 8'h01; // [RQ14]
        end
        else
        begin
            blanking_active <= 1'b0; // [RQ14]
        end
    end

    // ****************************************
    // write channel
    // ****************************************
    assign do_write = have_addr && have_data && write_state == write_idle;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            have_addr <= 1'b0;
            have_data <= 1'b0;
            write_addr <= 8'h00;
            write_data <= 32'h0000_0000;
            write_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
            write_state <= write_idle;
        end
        else
        begin
            s_axi_awready <= !have_addr && !s_axi_awready && s_axi_awvalid
                && write_state == write_idle;
            s_axi_wready <= !have_data && !s_axi_wready && s_axi_wvalid
                && write_state == write_idle;
            if (s_axi_awvalid && s_axi_awready)
            begin
                have_addr <= 1'b1;
                write_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                have_data <= 1'b1;
                write_data <= s_axi_wdata;
                write_strb <= s_axi_wstrb;
            end
            case (write_state)
                write_idle:
                begin
                    if (do_write)
                    begin
                        have_addr <= 1'b0;
                        have_data <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= is_mapped(write_addr) ? resp_okay : resp_slverr;
                        write_state <= write_resp;
                    end
                end
                write_resp:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        write_state <= write_idle;
                    end
                end
                default:
                begin
                    write_state <= write_idle;
                end
            endcase
        end
    end

    // ****************************************
    // writable settings; counters ignore writes
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            blanking_offset_setting <= offset_setting_reset;
            blanking_window_width <= window_width_reset;
            reference_point_select <= reference_is_period;
        end
        else if (do_write)
        begin
            case (write_addr)
                offset_setting_addr:
                begin
                    blanking_offset_setting <= merge_lanes(blanking_offset_setting,
                        write_data, write_strb);
                end
                window_width_addr:
                begin
                    if (write_strb[0])
                    begin
                        blanking_window_width <= write_data[7:0]; // [RQ5]
                    end
                end
                filter_control_addr:
                begin
                    if (write_strb[0])
                    begin
                        reference_point_select <= write_data[reference_select_bit];
                    end
                end
                default:
                begin
                    // offset and window counters are read only [RQ1] [RQ9]
                end
            endcase
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= resp_okay;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
                case (s_axi_araddr)
                    offset_setting_addr: s_axi_rdata <= {16'h0000, blanking_offset_setting};
                    offset_count_addr: s_axi_rdata <= {16'h0000, offset_count_value}; // [RQ1]
                    window_width_addr: s_axi_rdata <= {24'h000000, blanking_window_width};
                    window_count_addr: s_axi_rdata <= {24'h000000, window_count_value}; // [RQ9]
                    filter_control_addr: s_axi_rdata <= {31'h0000_0000, reference_point_select};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // blanking_window_counters

`default_nettype wire

// >>> bench/blanking_window_counters_properties.sv
`timescale 1ns/100ps
`default_nettype none
module blanking_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************
    // bus handshakes
    // ****************
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awready && s_axi_wready;
    endsequence
    property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
    property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
    a_ar_pulse: assert property (p_ar_pulse) else $error("arready longer than one cycle");
    property p_b_rise; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
    a_b_rise: assert property (p_b_rise) else $error("write response late");
    property p_r_rise; s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_rise: assert property (p_r_rise) else $error("read data late");
    property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_drop: assert property (p_b_drop) else $error("bvalid kept after bready");
    property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_drop: assert property (p_r_drop) else $error("rvalid kept after rready");
    property p_r_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_r_hi: assert property (p_r_hi) else $error("read data upper half not zero");
    property p_rel; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid; endproperty
    a_rel: assert property (p_rel) else $error("response out of reset");
endmodule // blanking_checker
bind blanking_window_counters blanking_checker u_chk (.*);
`default_nettype wire

// >>> bench/blanking_window_counters_test.sv
`timescale 1ns/100ps
`default_nettype none
module blanking_window_counters_test
    import blanking_pkg::*;
;
    logic aclk, aresetn, period_event, zero_event, emulation_halt, blanking_active;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, ws;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int failures, samples_checked, d, l;
    blanking_window_counters uut (.*);
    // ****************
    // helpers
    // ****************
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, b;
        ta = 0;
        tw = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        repeat (60)
        begin
            @(negedge aclk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            b = s_axi_bvalid;
            ws = s_axi_bresp;
            @(posedge aclk);
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
            if (b)
            begin
                s_axi_bready <= 0;
                @(posedge aclk);
                return;
            end
        end
        failures++;
        tally_and_finish;
    endtask
    task automatic rdr(input logic [7:0] a);
        logic t, r;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        repeat (60)
        begin
            @(negedge aclk);
            t |= s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            s_axi_arvalid <= !t;
            if (r)
            begin
                s_axi_rready <= 0;
                @(posedge aclk);
                return;
            end
        end
        failures++;
        tally_and_finish;
    endtask
    task automatic pulse(input logic z);
        @(posedge aclk);
        zero_event <= z;
        period_event <= !z;
        @(posedge aclk);
        zero_event <= 0;
        period_event <= 0;
    endtask
    task automatic span;
        l = 0;
        while (blanking_active && l < 300)
        begin
            @(posedge aclk);
            #1;
            l++;
        end
    endtask
    task automatic measure;
        d = 0;
        do
        begin
            @(posedge aclk);
            #1;
            d++;
        end
        while (!blanking_active && d < 300);
        if (d == 300)
            d = 0;
        span;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_regs;
        rdr(offset_setting_addr);
        chk("offset setting reset", rd, 32'h0);
        wr(offset_count_addr, 32'h0000_1234);
        chk("count write resp", ws, resp_okay);
        wr(window_count_addr, 32'h0000_0055);
        wr(8'h14, 32'h0000_0001);
        chk("unmapped write resp", ws, resp_slverr);
        rdr(offset_count_addr);
        chk("offset count", rd, 32'h0);
        rdr(window_count_addr);
        chk("window count", rd, 32'h0);
        rdr(8'h14);
        chk("unmapped resp", rs, resp_slverr);
        $display("test regs done");
    endtask
    task automatic t_window;
        wr(offset_setting_addr, 32'h5);
        wr(window_width_addr, 32'h3);
        emulation_halt <= 1;
        pulse(0);
        measure;
        chk("offset delay", d, 5);
        chk("window length", l, 3);
        rdr(offset_count_addr);
        chk("offset held", rd, 32'h0);
        rdr(window_count_addr);
        chk("window held", rd, 32'h0);
        emulation_halt <= 0;
        wr(window_width_addr, 32'h0);
        pulse(0);
        measure;
        chk("no window", d, 0);
        $display("test window done");
    endtask
    task automatic t_select;
        wr(window_width_addr, 32'h3);
        wr(filter_control_addr, 32'h1);
        rdr(filter_control_addr);
        chk("select readback", rd, 32'h1);
        rdr(window_width_addr);
        chk("width readback", rd, 32'h3);
        pulse(0);
        measure;
        chk("period ignored", d, 0);
        pulse(1);
        measure;
        chk("zero delay", d, 5);
        chk("zero length", l, 3);
        $display("test select done");
    endtask
    task automatic t_restart;
        wr(filter_control_addr, 32'h0);
        wr(offset_setting_addr, 32'h2);
        wr(window_width_addr, 32'h8);
        pulse(0);
        repeat (3) @(posedge aclk);
        period_event <= 1;
        @(posedge aclk);
        period_event <= 0;
        #1;
        chk("across period", blanking_active, 1);
        span;
        chk("restarted length", l, 10);
        $display("test restart done");
    endtask
    initial
    begin
        aclk = 0;
        forever #2 aclk = !aclk;
    end
    initial
    begin
        {aresetn, period_event, zero_event, emulation_halt} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        s_axi_wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_regs;
        t_window;
        t_select;
        t_restart;
        tally_and_finish;
    end
endmodule // blanking_window_counters_test
`default_nettype wire
